// File: lcp_ctrl_model.sv
`timescale 1ns/10ps
// ==========================================================
// Line card controller on the serial control line
module lcp_ctrl_model (
   output logic      serial_control_clock,
   output logic      serial_select_n,
   output logic      ctl_oe_n,
   output logic      ctl_d,
   input  wire logic serial_control_line
);
   initial begin
      serial_control_clock = 1'b0;
      serial_select_n = 1'b1;
      ctl_oe_n = 1'b1;
      ctl_d = 1'b1;
   end
   // Deselected clocks let the port leave reset and settle config
   task automatic idle(input int n);
      repeat (n) begin
         #6 serial_control_clock = 1'b1;
         #6 serial_control_clock = 1'b0;
      end
   endtask
   // nb bits per select, MSB first
   task automatic xfer(input logic [7:0] wd, input logic rd,
                       input int nb, output logic [7:0] q);
      serial_select_n = 1'b0;
      ctl_oe_n = rd;
      for (int k = 0; k < nb; k++) begin
         ctl_d = wd[7];
         wd = {wd[6:0], 1'b1};
         #6 q = {q[6:0], serial_control_line};
         serial_control_clock = 1'b1;
         #6 serial_control_clock = 1'b0;
      end
      #6 serial_select_n = 1'b1;
      ctl_oe_n = 1'b1;
      ctl_d = ~ctl_d;
      idle(8);
   endtask
endmodule

// File: lcp_pkg.sv
// ==========================================================
// Overview of operation
// - Direction read returns pin directions in bits 7..3, 1 is input.
// - Direction write sets pin directions from bits 7..3.
// - After reset all five control pins are inputs.
// - Level read returns pin levels in bits 7..3, status in bit 0.
// - Level write drives output pins from bits 7..3.
// - Opcodes B8..BA select linear, mu-law or A-law coding.
// - Association read returns rx pin, tx pin, rx and tx segment.
// - Opcodes 90..9F write the four association bits.
// - Pin select 1 uses the B pin, 0 the A pin.
// - Segment bit picks first or second 256-bit frame segment.
// - Loop clear drops every diagnostic condition.
// - Opcode B3 bypasses the transmit high-pass filter.
// - Opcode B1 adds 6 dB receive attenuation.
// - Opcode B2 holds the analog output at offset level.
// - Opcode B7 loops analog input to analog output.
// - Digital loop sends received word times 15/16 on transmit.
// - Slot active pin pulls low exactly while its output drives.
// - One word per frame on selected output, floating otherwise.
// - Transmit burst starts at programmed delay after frame sync.
// - One word per frame sampled on selected receive input.
// - Burst offset is high slot times eight plus low slot.
// - Serial bits move only while select is low, on data clock.
// - Select low over eight data clocks enters stand-alone mode.
package lcp_pkg;

   // ==========================================================
   // Opcodes and decode masks
   localparam logic [7:0] OP_DIR_RD   = 8'hC1;
   localparam logic [7:0] OP_DIR_WR   = 8'hD1;
   localparam logic [7:0] OP_LVL_RD   = 8'hC8;
   localparam logic [7:0] OP_LVL_WR   = 8'hD8;
   localparam logic [7:0] OP_CODE     = 8'hB8;
   localparam logic [7:0] OP_ASC_RD   = 8'h77;
   localparam logic [7:0] OP_ASC_WR   = 8'h90;
   localparam logic [7:0] OP_CLR      = 8'hB0;
   localparam logic [7:0] OP_ATT      = 8'hB1;
   localparam logic [7:0] OP_RXOFF    = 8'hB2;
   localparam logic [7:0] OP_HPBYP    = 8'hB3;
   localparam logic [7:0] OP_DLOOP    = 8'hB4;
   localparam logic [7:0] OP_ALOOP    = 8'hB7;
   localparam logic [7:0] OP_TXS_RD   = 8'h75;
   localparam logic [7:0] OP_RXS_RD   = 8'h7D;
   localparam logic [7:0] OP_TXS_HI   = 8'h20;
   localparam logic [7:0] OP_RXS_HI   = 8'h40;
   localparam logic [7:0] OP_TXS_LO   = 8'h60;
   localparam logic [7:0] OP_RXS_LO   = 8'h68;
   localparam logic [7:0] MSK_ALL     = 8'hFF;
   localparam logic [7:0] MSK_CODE    = 8'hFC;
   localparam logic [7:0] MSK_ASC     = 8'hF0;
   localparam logic [7:0] MSK_HI      = 8'hE0;
   localparam logic [7:0] MSK_LO      = 8'hF8;

   // ==========================================================
   // Fields, reset values and counts
   localparam logic [4:0] DIR_RST     = 5'h1F;
   localparam logic [4:0] LVL_RST     = 5'h00;
   localparam logic [2:0] PAD3        = 3'h0;
   localparam logic [1:0] PAD2        = 2'h0;
   localparam logic [3:0] PAD4        = 4'h0;
   localparam logic [7:0] BYTE_ZERO   = 8'h00;
   localparam logic [3:0] BIT_LAST    = 4'h7;
   localparam logic [3:0] BIT_OVER    = 4'h8;
   localparam logic [4:0] LEN_LIN     = 5'h10;
   localparam logic [4:0] LEN_CMP     = 5'h08;
   localparam logic [3:0] TOP_BIT     = 4'hF;
   localparam logic [9:0] POS_MAX     = 10'h3FF;
   localparam logic [15:0] RX_IDLE    = 16'h0000;

   typedef enum logic [1:0] {
      CODE_LIN  = 2'b00,
      CODE_MU   = 2'b01,
      CODE_ALAW = 2'b10,
      CODE_RSVD = 2'b11
   } lcp_code_t;

   typedef enum logic [1:0] {
      PEND_NONE = 2'b00,
      PEND_DIR  = 2'b01,
      PEND_LVL  = 2'b10,
      PEND_READ = 2'b11
   } lcp_pend_t;

   typedef struct packed {
      logic hp_byp;
      logic rx_att;
      logic rx_off;
      logic ana_loop;
      logic dig_loop;
   } lcp_diag_t;

   typedef struct packed {
      logic rx_b;
      logic tx_b;
      logic rx_seg;
      logic tx_seg;
   } lcp_assoc_t;

   typedef struct packed {
      logic [4:0] hi;
      logic [2:0] lo;
   } lcp_slot_t;

   typedef struct packed {
      logic [4:0] dir;
      logic [4:0] lvl;
      lcp_code_t  code;
      lcp_assoc_t assoc;
      lcp_slot_t  tx_slot;
      lcp_slot_t  rx_slot;
      lcp_diag_t  diag;
   } lcp_cfg_t;

   localparam lcp_cfg_t CFG_RST = '{dir: DIR_RST, lvl: LVL_RST,
      code: CODE_LIN, assoc: '0, tx_slot: '0, rx_slot: '0, diag: '0};

endpackage

// File: lcp_port_pcm_config.sv
`timescale 1ns/10ps
module lcp_port_pcm_config (
   input  wire logic              ref_clk,
   input  wire logic              srst,
   input  wire logic              serial_control_clock,
   input  wire logic              serial_select_n,
   input  wire logic              serial_control_line_in,
   output logic                   serial_control_line_out,
   output logic                   serial_control_line_oe_n,
   input  wire logic [4:0]        general_control_pins_in,
   output logic [4:0]             general_control_pins_out,
   output logic [4:0]             general_control_pins_oe_n,
   input  wire logic              line_status_in,
   output logic                   stand_alone,
   input  wire logic              tx_bit_clock,
   input  wire logic              tx_frame_sync,
   input  wire logic [15:0]       tx_sample,
   output logic                   tx_out_a,
   output logic                   tx_out_a_oe_n,
   output logic                   tx_out_b,
   output logic                   tx_out_b_oe_n,
   output logic                   slot_active_a,
   output logic                   slot_active_a_oe_n,
   output logic                   slot_active_b,
   output logic                   slot_active_b_oe_n,
   input  wire logic              rx_bit_clock,
   input  wire logic              rx_frame_sync,
   input  wire logic              rx_in_a,
   input  wire logic              rx_in_b,
   output logic [15:0]            rx_sample,
   output logic                   rx_sample_valid,
   output lcp_pkg::lcp_code_t     sample_code_select,
   output logic                   tx_highpass_bypass,
   output logic                   rx_attenuate,
   output logic                   rx_path_off,
   output logic                   analog_loopback,
   output logic                   digital_loopback
);
   import lcp_pkg::*;

   // ==========================================================
   // Local state types
   typedef struct packed {
      logic [3:0] cnt;
      logic [6:0] sh;
   } frm_t;

   typedef struct packed {
      lcp_cfg_t   cfg;
      lcp_pend_t  pend;
      logic [7:0] obuf;
      logic       tgl;
      logic       alone;
      logic [4:0] pin1;
      logic [4:0] pin2;
      logic [1:0] sts;
   } ser_t;

   typedef struct packed {
      logic [2:0] ck;
      logic [1:0] fs;
      logic [9:0] pos;
      logic       seen;
   } lane_t;

   typedef struct packed {
      logic [2:0]  tg;
      lcp_cfg_t    cfg;
      lane_t       tx;
      lane_t       rx;
      logic [1:0]  ra;
      logic [1:0]  rb;
      logic [15:0] txw;
      logic        txbit;
      logic [1:0]  txen;
      logic [15:0] rsh;
      logic [15:0] rcap;
      logic [15:0] rout;
      logic        rvld;
   } pcm_t;

   localparam ser_t SER_RST = '{cfg: CFG_RST, pend: PEND_NONE,
      default: '0};
   localparam pcm_t PCM_RST = '{cfg: CFG_RST, default: '0};

   // ==========================================================
   // Helpers
   function automatic logic op_is(input logic [7:0] op,
                                  input logic [7:0] base,
                                  input logic [7:0] msk);
      op_is = (op & msk) == base;
   endfunction

   function automatic logic rise(input lane_t l);
      rise = l.ck[1] & ~l.ck[2];
   endfunction

   function automatic lane_t lane_step(input lane_t l,
                                       input logic  ck,
                                       input logic  fs);
      lane_t n;
      n = l;
      n.ck = {l.ck[1:0], ck};
      n.fs = {l.fs[0], fs};
      if (rise(l)) begin
         if (l.fs[1]) begin
            n.pos = '0;
            n.seen = 1'b1;
         end else if (l.pos != POS_MAX) begin
            n.pos = l.pos + 10'd1;
         end
      end
      return n;
   endfunction

   function automatic logic [9:0] rel(input logic [9:0] p,
                                      input logic       seg,
                                      input lcp_slot_t  s);
      rel = p - {1'b0, seg, s.hi, s.lo};
   endfunction

   function automatic logic in_win(input lane_t      l,
                                   input logic       seg,
                                   input lcp_slot_t  s,
                                   input logic [4:0] len);
      in_win = l.seen && (l.pos >= {1'b0, seg, s.hi, s.lo})
         && (rel(l.pos, seg, s) < {5'h00, len});
   endfunction

   function automatic logic [15:0] scale(input logic [15:0] w);
      scale = w - {{4{w[15]}}, w[15:4]};
   endfunction

   // ==========================================================
   // Serial domain reset release
   // Asserts at once, releases on data clock edges
   logic [1:0] srst_pipe;
   logic       rst_ser;

   always_ff @(posedge serial_control_clock or posedge srst) begin
      if (srst) begin
         srst_pipe <= '1;
      end else begin
         srst_pipe <= {srst_pipe[0], 1'b0};
      end
   end
   assign rst_ser = srst_pipe[1];

   // ==========================================================
   // Serial bit framing
   // Select high clears the frame even with no clock running
   frm_t frm;
   frm_t next_frm;

   always_comb begin
      next_frm = frm;
      if (frm.cnt != BIT_OVER) begin
         next_frm.cnt = frm.cnt + 4'd1;
      end
      next_frm.sh = {frm.sh[5:0], serial_control_line_in};
   end

   // Bits move only while selected
   // Deselect wins over a clock edge in flight
   always_ff @(posedge serial_control_clock or posedge serial_select_n) begin
      if (serial_select_n) begin
         frm <= '0;
      end else begin
         frm <= next_frm;
      end
   end

   // ==========================================================
   // Instruction interpreter
   ser_t       ser;
   ser_t       next_ser;
   logic [7:0] rx_byte;
   logic       byte_done;
   logic [4:0] pin_lvl;

   assign rx_byte   = {frm.sh, serial_control_line_in};
   assign byte_done = !serial_select_n && (frm.cnt == BIT_LAST);

   always_comb begin
      next_ser = ser;
      next_ser.pin1 = general_control_pins_in;
      next_ser.pin2 = ser.pin1;
      next_ser.sts = {ser.sts[0], line_status_in};
      // Driven pins report their own level
      pin_lvl = (ser.cfg.dir & ser.pin2) | (~ser.cfg.dir & ser.cfg.lvl);
      if (!serial_select_n && frm.cnt == BIT_OVER) begin
         next_ser.alone = 1'b1;
      end
      if (!serial_select_n && ser.pend == PEND_READ
          && frm.cnt < BIT_LAST) begin
         next_ser.obuf = {ser.obuf[6:0], 1'b0};
      end
      if (byte_done) begin
         next_ser.tgl = ~ser.tgl;
         next_ser.pend = PEND_NONE;
         unique case (ser.pend)
            PEND_DIR: begin
               next_ser.cfg.dir = rx_byte[7:3];
            end
            PEND_LVL: begin
               next_ser.cfg.lvl = rx_byte[7:3];
            end
            PEND_READ: begin
               next_ser.obuf = BYTE_ZERO;
            end
            PEND_NONE: begin
               if (op_is(rx_byte, OP_DIR_RD, MSK_ALL)) begin
                  next_ser.obuf = {ser.cfg.dir, PAD3};
                  next_ser.pend = PEND_READ;
               end else if (op_is(rx_byte, OP_DIR_WR, MSK_ALL)) begin
                  next_ser.pend = PEND_DIR;
               end else if (op_is(rx_byte, OP_LVL_RD, MSK_ALL)) begin
                  next_ser.obuf = {pin_lvl, PAD2, ser.sts[1]};
                  next_ser.pend = PEND_READ;
               end else if (op_is(rx_byte, OP_LVL_WR, MSK_ALL)) begin
                  next_ser.pend = PEND_LVL;
               end else if (op_is(rx_byte, OP_CODE, MSK_CODE)) begin
                  if (rx_byte[1:0] != CODE_RSVD) begin
                     next_ser.cfg.code = lcp_code_t'(rx_byte[1:0]);
                  end
               end else if (op_is(rx_byte, OP_ASC_RD, MSK_ALL)) begin
                  next_ser.obuf = {PAD4, ser.cfg.assoc};
                  next_ser.pend = PEND_READ;
               end else if (op_is(rx_byte, OP_ASC_WR, MSK_ASC)) begin
                  next_ser.cfg.assoc = rx_byte[3:0];
               end else if (op_is(rx_byte, OP_CLR, MSK_ALL)) begin
                  next_ser.cfg.diag = '0;
               end else if (op_is(rx_byte, OP_ATT, MSK_ALL)) begin
                  next_ser.cfg.diag.rx_att = 1'b1;
               end else if (op_is(rx_byte, OP_RXOFF, MSK_ALL)) begin
                  next_ser.cfg.diag.rx_off = 1'b1;
               end else if (op_is(rx_byte, OP_HPBYP, MSK_ALL)) begin
                  next_ser.cfg.diag.hp_byp = 1'b1;
               end else if (op_is(rx_byte, OP_DLOOP, MSK_ALL)) begin
                  next_ser.cfg.diag.dig_loop = 1'b1;
               end else if (op_is(rx_byte, OP_ALOOP, MSK_ALL)) begin
                  next_ser.cfg.diag.ana_loop = 1'b1;
               end else if (op_is(rx_byte, OP_TXS_RD, MSK_ALL)) begin
                  next_ser.obuf = ser.cfg.tx_slot;
                  next_ser.pend = PEND_READ;
               end else if (op_is(rx_byte, OP_RXS_RD, MSK_ALL)) begin
                  next_ser.obuf = ser.cfg.rx_slot;
                  next_ser.pend = PEND_READ;
               end else if (op_is(rx_byte, OP_TXS_HI, MSK_HI)) begin
                  next_ser.cfg.tx_slot.hi = rx_byte[4:0];
               end else if (op_is(rx_byte, OP_RXS_HI, MSK_HI)) begin
                  next_ser.cfg.rx_slot.hi = rx_byte[4:0];
               end else if (op_is(rx_byte, OP_TXS_LO, MSK_LO)) begin
                  next_ser.cfg.tx_slot.lo = rx_byte[2:0];
               end else if (op_is(rx_byte, OP_RXS_LO, MSK_LO)) begin
                  next_ser.cfg.rx_slot.lo = rx_byte[2:0];
               end
            end
         endcase
      end
   end

   always_ff @(posedge serial_control_clock or posedge rst_ser) begin
      if (rst_ser) begin
         ser <= SER_RST;
      end else begin
         ser <= next_ser;
      end
   end

   assign general_control_pins_out  = ser.cfg.lvl;
   assign general_control_pins_oe_n = ser.cfg.dir;
   assign stand_alone               = ser.alone;
   // Line driven only in a read frame
   assign serial_control_line_out   = ser.obuf[7];
   assign serial_control_line_oe_n  = serial_select_n
                                      | (ser.pend != PEND_READ);

   // ==========================================================
   // PCM side, reference clock domain
   // Config bus is copied on a synced toggle; it is stable for
   // at least one select frame, longer than the three-cycle copy
   pcm_t        pcm;
   pcm_t        next_pcm;
   logic [4:0]  len;
   logic [9:0]  tx_rel;
   logic [9:0]  rx_rel;
   logic        tx_hit;
   logic        rx_hit;
   logic        rx_bit;
   logic [15:0] rx_new;

   always_comb begin
      next_pcm = pcm;
      next_pcm.tg = {pcm.tg[1:0], ser.tgl};
      if (pcm.tg[1] ^ pcm.tg[2]) begin
         next_pcm.cfg = ser.cfg;
      end
      len = (pcm.cfg.code == CODE_LIN) ? LEN_LIN : LEN_CMP;
      next_pcm.tx = lane_step(pcm.tx, tx_bit_clock, tx_frame_sync);
      next_pcm.rx = lane_step(pcm.rx, rx_bit_clock, rx_frame_sync);
      next_pcm.ra = {pcm.ra[0], rx_in_a};
      next_pcm.rb = {pcm.rb[0], rx_in_b};
      next_pcm.rvld = 1'b0;
      tx_rel = rel(next_pcm.tx.pos, pcm.cfg.assoc.tx_seg,
                   pcm.cfg.tx_slot);
      tx_hit = in_win(next_pcm.tx, pcm.cfg.assoc.tx_seg,
                      pcm.cfg.tx_slot, len);
      rx_rel = rel(next_pcm.rx.pos, pcm.cfg.assoc.rx_seg,
                   pcm.cfg.rx_slot);
      rx_hit = in_win(next_pcm.rx, pcm.cfg.assoc.rx_seg,
                      pcm.cfg.rx_slot, len);
      rx_bit = pcm.cfg.assoc.rx_b ? pcm.rb[1] : pcm.ra[1];
      rx_new = {pcm.rsh[14:0], rx_bit};

      if (rise(pcm.tx)) begin
         if (pcm.tx.fs[1]) begin
            next_pcm.txw = pcm.cfg.diag.dig_loop ? scale(pcm.rcap)
                                                 : tx_sample;
         end
         next_pcm.txen[1] = tx_hit & pcm.cfg.assoc.tx_b;
         next_pcm.txen[0] = tx_hit & ~pcm.cfg.assoc.tx_b;
         if (tx_hit) begin
            next_pcm.txbit = next_pcm.txw[TOP_BIT - tx_rel[3:0]];
         end
      end

      if (rise(pcm.rx) && rx_hit) begin
         next_pcm.rsh = rx_new;
         if (rx_rel[4:0] == len - 5'd1) begin
            next_pcm.rcap = (len == LEN_LIN) ? rx_new
                                             : {rx_new[7:0], BYTE_ZERO};
            next_pcm.rout = next_pcm.rcap;
            next_pcm.rvld = ~pcm.cfg.diag.rx_off;
         end
      end
      if (pcm.cfg.diag.rx_off) begin
         next_pcm.rout = RX_IDLE;
      end
   end

   always_ff @(posedge ref_clk) begin
      if (srst) begin
         pcm <= PCM_RST;
      end else begin
         pcm <= next_pcm;
      end
   end

   // ==========================================================
   // PCM pins and path controls
   // Transmit pin select
   assign tx_out_a           = pcm.txbit;
   assign tx_out_b           = pcm.txbit;
   assign tx_out_a_oe_n      = ~pcm.txen[0];
   assign tx_out_b_oe_n      = ~pcm.txen[1];
   // Same enable as the data pin
   assign slot_active_a      = 1'b0;
   assign slot_active_b      = 1'b0;
   assign slot_active_a_oe_n = ~pcm.txen[0];
   assign slot_active_b_oe_n = ~pcm.txen[1];
   assign rx_sample          = pcm.rout;
   assign rx_sample_valid    = pcm.rvld;
   assign sample_code_select = pcm.cfg.code;
   assign tx_highpass_bypass = pcm.cfg.diag.hp_byp;
   assign rx_attenuate       = pcm.cfg.diag.rx_att;
   assign rx_path_off        = pcm.cfg.diag.rx_off;
   assign analog_loopback    = pcm.cfg.diag.ana_loop;
   // Loop control to the signal core
   assign digital_loopback   = pcm.cfg.diag.dig_loop;

endmodule

// File: lcp_port_pcm_config_properties.sv
`timescale 1ns/10ps
// ==========================================================
// Port checker
module lcp_checker (
   input wire logic               ref_clk,
   input wire logic               srst,
   input wire logic               serial_select_n,
   input wire logic               serial_control_line_oe_n,
   input wire logic [4:0]         general_control_pins_oe_n,
   input wire logic               stand_alone,
   input wire logic               tx_out_a_oe_n,
   input wire logic               tx_out_b_oe_n,
   input wire logic               slot_active_a,
   input wire logic               slot_active_a_oe_n,
   input wire logic               slot_active_b,
   input wire logic               slot_active_b_oe_n,
   input wire logic [15:0]        rx_sample,
   input wire logic               rx_sample_valid,
   input wire logic               rx_path_off,
   input wire lcp_pkg::lcp_code_t sample_code_select
);
   import lcp_pkg::*;
   default clocking @(posedge ref_clk);
   endclocking
   default disable iff (srst);
   // ==========================================================
   // Assertions
   slot_a_track_a: assert property (
      !slot_active_a && slot_active_a_oe_n == tx_out_a_oe_n)
      else $error("slot A enable differs from output A");
   slot_b_track_a: assert property (
      !slot_active_b && slot_active_b_oe_n == tx_out_b_oe_n)
      else $error("slot B enable differs from output B");
   one_tx_pin_a: assert property (tx_out_a_oe_n || tx_out_b_oe_n)
      else $error("both transmit outputs driven");
   // Shortest burst is eight bits of many ref cycles each
   burst_hold_a: assert property (
      $fell(tx_out_b_oe_n) |=> !tx_out_b_oe_n [*8])
      else $error("transmit burst cut short");
   // Must hold across reset itself, so no disable here
   pins_reset_a: assert property (disable iff (1'b0)
      srst |=> general_control_pins_oe_n == 5'h1F)
      else $error("control pins not inputs in reset");
   line_quiet_a: assert property (
      serial_select_n |-> serial_control_line_oe_n)
      else $error("serial line driven while deselected");
   code_legal_a: assert property (
      sample_code_select != CODE_RSVD)
      else $error("reserved coding selected");
   sticky_mode_a: assert property (stand_alone |=> stand_alone)
      else $error("stand-alone mode dropped");
   word_pulse_a: assert property (
      rx_sample_valid |=> !rx_sample_valid)
      else $error("receive word flagged twice");
   rx_mute_a: assert property (
      rx_path_off && $past(rx_path_off, 2) |->
      rx_sample == 16'h0000 && !rx_sample_valid)
      else $error("receive data passed while path off");
   cover property ($fell(tx_out_b_oe_n));
   cover property (rx_sample_valid);
   cover property ($rose(stand_alone));
endmodule

bind lcp_port_pcm_config lcp_checker chk_u (
   .ref_clk, .srst, .serial_select_n, .serial_control_line_oe_n,
   .general_control_pins_oe_n, .stand_alone, .tx_out_a_oe_n,
   .tx_out_b_oe_n, .slot_active_a, .slot_active_a_oe_n, .slot_active_b,
   .slot_active_b_oe_n, .rx_sample, .rx_sample_valid, .rx_path_off,
   .sample_code_select);

// File: test_lcp_port_pcm_config.sv
`timescale 1ns/10ps
module test_lcp_port_pcm_config;
   import lcp_pkg::*;
   // ==========================================================
   // Bench signals
   logic        ref_clk = 1'b0;
   logic        srst = 1'b1;
   logic        pclk = 1'b0;
   logic        fsync = 1'b0;
   logic        rxd = 1'b0;
   logic        sts = 1'b1;
   logic [4:0]  ext = 5'h11;
   logic [15:0] tx_sample = 16'hA5C3;
   logic [15:0] rx_sample, got_rx, word;
   logic [7:0]  q;
   logic [4:0]  pins_out, pins_oe_n;
   logic        rx_sample_valid, stand_alone, txa_oe_n, txb_oe_n, txb, txa;
   lcp_code_t   sample_code_select;
   wire  [4:0]  dg;
   wire         serial_control_clock, serial_select_n, ctl_oe_n, ctl_d;
   wire         line_out, line_oe_n;
   wire  [4:0]  pins = (pins_out & ~pins_oe_n) | (ext & pins_oe_n);
   // Pull-up holds the line high when nobody drives it
   wire         line = !line_oe_n ? line_out : (!ctl_oe_n ? ctl_d : 1'b1);
   int          errors = 0;
   int          cmp_count = 0;

   lcp_port_pcm_config dut_u (
      .ref_clk, .srst, .serial_control_clock, .serial_select_n,
      .serial_control_line_in(line), .serial_control_line_out(line_out),
      .serial_control_line_oe_n(line_oe_n),
      .general_control_pins_in(pins), .general_control_pins_out(pins_out),
      .general_control_pins_oe_n(pins_oe_n), .line_status_in(sts),
      .stand_alone, .tx_bit_clock(pclk), .tx_frame_sync(fsync), .tx_sample,
      .tx_out_a(txa), .tx_out_a_oe_n(txa_oe_n), .tx_out_b(txb),
      .tx_out_b_oe_n(txb_oe_n), .slot_active_a(), .slot_active_a_oe_n(),
      .slot_active_b(), .slot_active_b_oe_n(), .rx_bit_clock(pclk),
      .rx_frame_sync(fsync), .rx_in_a(~rxd), .rx_in_b(rxd), .rx_sample,
      .rx_sample_valid, .sample_code_select, .tx_highpass_bypass(dg[4]),
      .rx_attenuate(dg[3]), .rx_path_off(dg[2]), .analog_loopback(dg[1]),
      .digital_loopback(dg[0]));
   lcp_ctrl_model ctrl_u (
      .serial_control_clock, .serial_select_n, .ctl_oe_n, .ctl_d,
      .serial_control_line(line));

   always #10 ref_clk = ~ref_clk;
   always @(posedge ref_clk) if (rx_sample_valid) got_rx <= rx_sample;

   // ==========================================================
   // Helpers
   task automatic chk(input logic [15:0] g, input logic [15:0] e);
      cmp_count++;
      if (g !== e) begin
         $display("Error %0t: got %h expected %h", $time, g, e);
         errors++;
      end
   endtask
   task automatic cmd(input logic [7:0] op);
      ctrl_u.xfer(op, 1'b0, 8, q);
      repeat (4) @(negedge ref_clk);
   endtask
   task automatic io(input logic [7:0] op, input logic rd,
                     input logic [7:0] d);
      ctrl_u.xfer(op, 1'b0, 8, q);
      ctrl_u.xfer(d, rd, 8, q);
   endtask
   // One PCM frame; both directions share the bit clock and sync
   task automatic frame(input logic [15:0] rw, input logic sel_b,
                        output logic [15:0] tw, output int first);
      first = -1;
      tw = 16'h0000;
      for (int k = 0; k < 290; k++) begin
         fsync = (k == 0);
         rxd = (k < 16) ? rw[15 - k] : k[0];
         @(negedge ref_clk);
         pclk = 1'b1;
         repeat (6) @(negedge ref_clk);
         if (!(sel_b ? txb_oe_n : txa_oe_n)) begin
            if (first < 0) first = k;
            tw = {tw[14:0], sel_b ? txb : txa};
         end
         chk(16'(sel_b ? txa_oe_n : txb_oe_n), 16'h0001);
         pclk = 1'b0;
         repeat (6) @(negedge ref_clk);
      end
   endtask

   // ==========================================================
   // Scenarios
   task automatic t_ports;
      chk(16'(pins_oe_n), 16'h001F);
      io(OP_DIR_WR, 1'b0, 8'hAF);
      chk(16'(pins_oe_n), 16'h0015);
      io(OP_DIR_RD, 1'b1, 8'hFF);
      chk(16'(q), 16'h00A8);
      io(OP_LVL_WR, 1'b0, 8'h57);
      chk(16'(pins_out & ~pins_oe_n), 16'h000A);
      io(OP_LVL_RD, 1'b1, 8'hFF);
      chk(16'(q), 16'h00D9);
      sts = 1'b0;
      io(OP_LVL_RD, 1'b1, 8'hFF);
      chk(16'(q), 16'h00D8);
   endtask
   task automatic t_code;
      for (int c = 2; c >= 0; c--) begin
         cmd(OP_CODE | 8'(c));
         chk(16'(sample_code_select), 16'(c));
      end
      // An opcode outside the B8..BB group must not touch the coding; code 11 is never sent
      cmd(OP_CODE ^ 8'h05);
      chk(16'(sample_code_select), 16'h0000);
   endtask
   task automatic t_diag;
      logic [7:0] ops [5] = '{OP_HPBYP, OP_ATT, OP_RXOFF, OP_ALOOP, OP_DLOOP};
      for (int i = 0; i < 5; i++) begin
         cmd(ops[i]);
         chk(16'(dg[4 - i]), 16'h0001);
      end
      cmd(OP_CLR);
      chk(16'(dg), 16'h0000);
   endtask
   task automatic t_pcm;
      int f;
      cmd(OP_ASC_WR | 8'h0C);
      io(OP_ASC_RD, 1'b1, 8'hFF);
      chk(16'(q), 16'h000C);
      cmd(OP_TXS_HI | 8'h01);
      cmd(OP_TXS_LO | 8'h02);
      io(OP_TXS_RD, 1'b1, 8'hFF);
      chk(16'(q), 16'h000A);
      frame(16'h1234, 1'b1, word, f);
      chk(16'(f), 16'h000A);
      chk(word, 16'hA5C3);
      chk(got_rx, 16'h1234);
      cmd(OP_ASC_WR | 8'h0D);
      frame(16'h4321, 1'b1, word, f);
      chk(16'(f), 16'h010A);
      chk(got_rx, 16'h4321);
      cmd(OP_ASC_WR | 8'h00);
      frame(16'h1234, 1'b0, word, f);
      chk(16'(f), 16'h000A);
      chk(word, 16'hA5C3);
      chk(got_rx, 16'hEDCB);
      cmd(OP_ASC_WR | 8'h0C);
      cmd(OP_DLOOP);
      frame(16'h1234, 1'b1, word, f);
      frame(16'h1234, 1'b1, word, f);
      chk(word, 16'h1111);
      cmd(OP_CLR);
   endtask
   task automatic t_alone;
      chk(16'(stand_alone), 16'h0000);
      ctrl_u.xfer(8'hFF, 1'b0, 9, q);
      repeat (4) @(negedge ref_clk);
      chk(16'(stand_alone), 16'h0001);
   endtask

   task automatic conclude;
      if (errors == 0 && cmp_count > 0)
         $display("STATUS OK");
      else
         $display("STATUS NOT OK");
      $finish;
   endtask

   initial begin
      // Serial clocks in reset give the serial side its reset edge
      fork
         ctrl_u.idle(2);
         repeat (4) @(negedge ref_clk);
      join
      srst = 1'b0;
      ctrl_u.idle(4);
      t_ports();
      t_code();
      t_diag();
      t_pcm();
      t_alone();
      conclude();
   end
   initial begin
      #2000000;
      errors++;
      conclude();
   end
endmodule
